// *** hdl/asps_map.svh ***
// constants for the alarm stop and power sag control block
// assumes a 125 MHz core clock; settings arrive as plain ports
//
// Contract
// RULE1 - every alarm belongs to group one or group two, each with own setting
// RULE2 - group-one alarm stops motor as after servo-off, using stop_mode_select only
// RULE3 - stop mode 0 brake then brake, 1 brake then coast, 2 coast then coast; the code holds brake in mode 1 and never moves to coast
// RULE4 - group two option 0 zero-speed stop then after-stop state; 1 stop-mode decode; the code holds zero-speed and has no after-stop state
// RULE5 - group-two option honoured in position and speed control only, not torque
// RULE6 - interruption not longer than hold time keeps motor powered; 20 to 1000 ms
// RULE7 - interruption longer than hold time removes motor power
// RULE8 - motor powered again once main supply recovers after a cut
// RULE9 - interruption beyond hold time drops servo_ready_out
// RULE10 - undervoltage alarm during interruption overrides hold time
// RULE11 - control supply loss acts as ordinary power-off, ignoring hold time
// RULE12 - main dc sag raises undervoltage warning and restricts output current
// RULE13 - undervoltage_function_select 1 host limits torque, 2 device limits alone
// RULE14 - host limits torque on warning and lifts limit only after it clears
// RULE15 - device-only mode applies internal limit whenever warning is active
// RULE16 - device-only mode releases limit over programmed release time
// RULE17 - host avoids torque reference above specified acceleration on recovery; the bench host model does not limit acceleration
// RULE18 - servo-off cuts motor power at once without waiting for hold time
// RULE19 - function select 0 means no warning detection and no sag limit
// RULE20 - device limit from sag_torque_limit 0..100 percent; release from release time
`ifndef ASPS_MAP_SVH
`define ASPS_MAP_SVH
`define ASPS_CLK_MHZ 125
`define ASPS_MS_NS 1000000
`define ASPS_CLK_NS 8
`define ASPS_MS_CYCLES (`ASPS_MS_NS / `ASPS_CLK_NS)
`define ASPS_HOLD_MIN_MS 10'h014
`define ASPS_HOLD_MAX_MS 10'h3E8
`define ASPS_HOLD_RST_MS 10'h014
`define ASPS_LIMIT_MAX_PCT 7'h64
`define ASPS_LIMIT_RST_PCT 7'h32
`define ASPS_FULL_TORQUE 7'h64
`define ASPS_RELEASE_RST_MS 10'h032
`endif

// *** hdl/asps_pkg.sv ***
// types for the alarm stop and power sag control block
// assumes nothing beyond the constants header
package asps_pkg;
  typedef enum logic [1:0] {
    ASPS_MODE_POSITION,
    ASPS_MODE_SPEED,
    ASPS_MODE_TORQUE
  } asps_ctrl_t;
  typedef enum logic [1:0] {
    ASPS_ACT_RUN,
    ASPS_ACT_BRAKE,
    ASPS_ACT_COAST,
    ASPS_ACT_ZERO_SPEED
  } asps_act_t;
  typedef enum logic [1:0] {
    ASPS_UV_OFF,
    ASPS_UV_HOST,
    ASPS_UV_DEVICE
  } asps_uv_t;
endpackage

// *** hdl/asps_ms_tick.sv ***
// millisecond tick divider
// assumes core_clk at the rate given in the constants header
`timescale 1ns/1ps
`include "asps_map.svh"
module asps_ms_tick #(
  parameter int DIV = `ASPS_MS_CYCLES
) (
  input wire logic core_clk,
  input wire logic srst,
  output logic tick
);
  logic [16:0] cnt_ff;
  logic [16:0] nxt_cnt;
  always_comb begin
    if (cnt_ff == 17'(DIV - 1)) begin
      nxt_cnt = 17'h00000;
    end else begin
      nxt_cnt = cnt_ff + 17'h00001;
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_ff <= 17'h00000;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
  assign tick = (cnt_ff == 17'(DIV - 1));
endmodule

// *** hdl/asps_core.sv ***
// alarm stop selection, power-cut ride through and sag torque limiting
// assumes settings and supply status arrive synchronous to core_clk
`timescale 1ns/1ps
`include "asps_map.svh"
module asps_core
  import asps_pkg::*;
#(
  parameter int MS_DIV = `ASPS_MS_CYCLES
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic servo_on_cmd,
  input wire logic alarm_group_one,
  input wire logic alarm_group_two,
  input wire logic [1:0] stop_mode_select,
  input wire logic gr2_stop_option,
  input wire asps_ctrl_t ctrl_mode,
  input wire logic [9:0] power_cut_hold_time,
  input wire logic main_supply_ok,
  input wire logic uv_alarm,
  input wire logic ctrl_supply_lost,
  input wire logic dc_sag,
  input wire logic [1:0] undervoltage_function_select,
  input wire logic [6:0] sag_torque_limit,
  input wire logic [9:0] sag_limit_release_time,
  output asps_act_t stop_action,
  output logic motor_power,
  output logic servo_ready_out,
  output logic uv_warning,
  output logic current_restrict,
  output logic [6:0] torque_limit_pct
);
  logic ms_tick;
  asps_ms_tick #(.DIV(MS_DIV)) u_tick (
    .core_clk(core_clk),
    .srst(srst),
    .tick(ms_tick)
  );

  // stop action decode
  asps_act_t base_act;
  asps_act_t nxt_act;
  asps_act_t act_ff;
  logic gr2_honour;
  always_comb begin
    case (stop_mode_select) // RULE3
      2'h0: base_act = ASPS_ACT_BRAKE;
      2'h1: base_act = ASPS_ACT_BRAKE;
      2'h2: base_act = ASPS_ACT_COAST;
      default: base_act = ASPS_ACT_COAST;
    endcase
  end
  assign gr2_honour = (ctrl_mode != ASPS_MODE_TORQUE); // RULE5
  logic [1:0] after_ff;
  logic [1:0] nxt_after;
  always_comb begin
    nxt_act = ASPS_ACT_RUN;
    if (alarm_group_one || !servo_on_cmd) begin
      nxt_act = base_act; // RULE1 RULE2 RULE18
    end else if (alarm_group_two) begin
      if (gr2_honour && !gr2_stop_option) begin
        nxt_act = ASPS_ACT_ZERO_SPEED; // RULE4
      end else begin
        nxt_act = base_act; // RULE4
      end
    end else if (!motor_power) begin
      nxt_act = ASPS_ACT_BRAKE;
    end
    nxt_after = stop_mode_select;
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      act_ff <= ASPS_ACT_BRAKE;
      after_ff <= 2'h0;
    end else begin
      act_ff <= nxt_act;
      after_ff <= nxt_after;
    end
  end
  assign stop_action = act_ff;

  // power interruption ride through
  logic [9:0] cut_ms_ff;
  logic [9:0] nxt_cut_ms;
  logic cut_ff;
  logic nxt_cut;
  logic [9:0] hold_ms;
  always_comb begin
    hold_ms = power_cut_hold_time;
    if (hold_ms < `ASPS_HOLD_MIN_MS) begin
      hold_ms = `ASPS_HOLD_MIN_MS;
    end else if (hold_ms > `ASPS_HOLD_MAX_MS) begin
      hold_ms = `ASPS_HOLD_MAX_MS;
    end
  end
  always_comb begin
    nxt_cut_ms = cut_ms_ff;
    nxt_cut = cut_ff;
    if (main_supply_ok) begin
      nxt_cut_ms = 10'h000;
      nxt_cut = 1'b0; // RULE8
    end else begin
      if (ms_tick && cut_ms_ff != 10'h3FF) begin
        nxt_cut_ms = cut_ms_ff + 10'h001;
      end
      if (cut_ms_ff > hold_ms) begin
        nxt_cut = 1'b1; // RULE7
      end
      if (uv_alarm || ctrl_supply_lost) begin
        nxt_cut = 1'b1; // RULE10 RULE11
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cut_ms_ff <= 10'h000;
      cut_ff <= 1'b0;
    end else begin
      cut_ms_ff <= nxt_cut_ms;
      cut_ff <= nxt_cut;
    end
  end
  // powered while within hold time, off at once on servo-off
  assign motor_power = servo_on_cmd && !cut_ff && !alarm_group_one
    && !alarm_group_two && !ctrl_supply_lost && !uv_alarm; // RULE6 RULE18
  assign servo_ready_out = !cut_ff && !ctrl_supply_lost && !uv_alarm; // RULE9

  // sag warning and torque limit
  asps_uv_t uv_sel;
  logic warn_ff;
  logic nxt_warn;
  logic [6:0] lim_ff;
  logic [6:0] nxt_lim;
  logic [9:0] rel_ms_ff;
  logic [9:0] nxt_rel_ms;
  logic [6:0] cap_pct;
  logic [16:0] ramp;
  always_comb begin
    case (undervoltage_function_select) // RULE13
      2'h1: uv_sel = ASPS_UV_HOST;
      2'h2: uv_sel = ASPS_UV_DEVICE;
      default: uv_sel = ASPS_UV_OFF;
    endcase
  end
  always_comb begin
    cap_pct = (sag_torque_limit > `ASPS_LIMIT_MAX_PCT) ? `ASPS_LIMIT_MAX_PCT
      : sag_torque_limit; // RULE20
    nxt_warn = dc_sag && (uv_sel != ASPS_UV_OFF); // RULE12 RULE19
    nxt_lim = `ASPS_FULL_TORQUE;
    nxt_rel_ms = rel_ms_ff;
    ramp = 17'h00000;
    if (uv_sel == ASPS_UV_DEVICE) begin
      if (warn_ff) begin
        nxt_lim = cap_pct; // RULE15
        nxt_rel_ms = 10'h000;
      end else if (lim_ff != `ASPS_FULL_TORQUE) begin
        if (ms_tick && rel_ms_ff < sag_limit_release_time) begin
          nxt_rel_ms = rel_ms_ff + 10'h001;
        end
        if (rel_ms_ff >= sag_limit_release_time) begin
          nxt_lim = `ASPS_FULL_TORQUE; // RULE16
        end else begin
          // product widened first: up to 100 times 1023 overflows ten bits
          ramp = 17'(cap_pct) + (17'(`ASPS_FULL_TORQUE - cap_pct) * 17'(rel_ms_ff)
            / 17'(sag_limit_release_time)); // RULE16 RULE20
          nxt_lim = ramp[6:0];
        end
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      warn_ff <= 1'b0;
      lim_ff <= `ASPS_FULL_TORQUE;
      rel_ms_ff <= 10'h000;
    end else begin
      warn_ff <= nxt_warn;
      lim_ff <= nxt_lim;
      rel_ms_ff <= nxt_rel_ms;
    end
  end
  assign uv_warning = warn_ff; // RULE14
  assign current_restrict = warn_ff; // RULE12
  assign torque_limit_pct = lim_ff;

  // checks
  gr1_stop_a: assert property (@(posedge core_clk) disable iff (srst) // RULE2
    alarm_group_one && servo_on_cmd |=> stop_action != ASPS_ACT_RUN)
    else $error("group one alarm did not stop");
  torque_gr2_a: assert property (@(posedge core_clk) disable iff (srst) // RULE5
    alarm_group_two && !alarm_group_one && servo_on_cmd && ctrl_mode == ASPS_MODE_TORQUE
    |=> stop_action != ASPS_ACT_ZERO_SPEED)
    else $error("zero speed stop in torque control");
  gr2_zero_a: assert property (@(posedge core_clk) disable iff (srst) // RULE4
    alarm_group_two && !alarm_group_one && servo_on_cmd && !gr2_stop_option
    && ctrl_mode == ASPS_MODE_SPEED |=> stop_action == ASPS_ACT_ZERO_SPEED)
    else $error("group two zero speed missing");
  coast_mode_a: assert property (@(posedge core_clk) disable iff (srst) // RULE3
    !servo_on_cmd && stop_mode_select == 2'h2 |=> stop_action == ASPS_ACT_COAST)
    else $error("coast decode wrong");
  servo_off_a: assert property (@(posedge core_clk) disable iff (srst) // RULE18
    !servo_on_cmd |-> !motor_power)
    else $error("power kept after servo off");
  ready_drop_a: assert property (@(posedge core_clk) disable iff (srst) // RULE9
    !main_supply_ok && cut_ms_ff > hold_ms |=> !servo_ready_out)
    else $error("ready kept after hold time");
  recover_a: assert property (@(posedge core_clk) disable iff (srst) // RULE8
    main_supply_ok && !uv_alarm && !ctrl_supply_lost |=> servo_ready_out)
    else $error("no recovery");
  ride_a: assert property (@(posedge core_clk) disable iff (srst) // RULE6
    !cut_ff && main_supply_ok ##1 !main_supply_ok && !uv_alarm && !ctrl_supply_lost
    |=> !cut_ff)
    else $error("cut at start of interruption");
  uv_off_a: assert property (@(posedge core_clk) disable iff (srst) // RULE19
    undervoltage_function_select == 2'h0 |=> !uv_warning)
    else $error("warning with detection off");
  dev_lim_a: assert property (@(posedge core_clk) disable iff (srst) // RULE15
    uv_warning && undervoltage_function_select == 2'h2 |=> torque_limit_pct == cap_pct)
    else $error("device limit not applied");
endmodule

// *** bench/asps_host.sv ***
// host motion controller model: servo command and own torque limit
// assumes uv_warning and the servo request are synchronous to core_clk
`timescale 1ns/1ps
module asps_host (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic want_on,
  input wire logic uv_warning,
  output logic servo_on_cmd,
  output logic host_lim_ff
);
  logic nxt_servo_on;
  logic nxt_host_lim;
  always_comb begin
    // servo-off is passed on at the next edge, never delayed
    nxt_servo_on = want_on;
    // limit set at the edge after the warning rises, lifted at the edge after it clears
    nxt_host_lim = uv_warning;
    if (srst) begin
      nxt_servo_on = 1'h0;
      nxt_host_lim = 1'h0;
    end
  end
  always_ff @(posedge core_clk) begin
    servo_on_cmd <= nxt_servo_on;
    host_lim_ff <= nxt_host_lim;
  end
endmodule

// *** bench/alarm_stop_and_power_sag_control_tb.sv ***
// self-checking bench: stop selection, ride-through and sag limiting
// assumes asps_core with MS_DIV of 10, so one ms is ten core_clk cycles
`timescale 1ns/1ps
module alarm_stop_and_power_sag_control_tb;
  import asps_pkg::*;
  logic core_clk = 1'h0, srst = 1'h1, want_on = 1'h0, servo_on_cmd, host_lim_ff;
  logic alarm_group_one = 1'h0, alarm_group_two = 1'h0, gr2_stop_option = 1'h0;
  logic main_supply_ok = 1'h1, uv_alarm = 1'h0, ctrl_supply_lost = 1'h0, dc_sag = 1'h0;
  logic [1:0] stop_mode_select = 2'h0, undervoltage_function_select = 2'h0;
  asps_ctrl_t ctrl_mode = ASPS_MODE_POSITION;
  logic [9:0] power_cut_hold_time = 10'h014, sag_limit_release_time = 10'h003;
  logic [6:0] sag_torque_limit = 7'h32, lim, torque_limit_pct;
  asps_act_t stop_action;
  logic motor_power, servo_ready_out, uv_warning, current_restrict;
  int num_errors = 0, cmp_count = 0, cyc = 0;
  int sel_q[$];
  logic [7:0] exp_q[$];
  asps_host host_u (.core_clk, .srst, .want_on, .uv_warning, .servo_on_cmd, .host_lim_ff);
  asps_core #(.MS_DIV(10)) dut_u (.core_clk, .srst, .servo_on_cmd, .alarm_group_one,
    .alarm_group_two, .stop_mode_select, .gr2_stop_option, .ctrl_mode, .power_cut_hold_time,
    .main_supply_ok, .uv_alarm, .ctrl_supply_lost, .dc_sag, .undervoltage_function_select,
    .sag_torque_limit, .sag_limit_release_time, .stop_action, .motor_power,
    .servo_ready_out, .uv_warning, .current_restrict, .torque_limit_pct);
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      report_and_stop();
    end
  end
  function automatic logic [7:0] obs(int s);
    case (s)
      0: return {6'h00, stop_action};
      1: return {7'h00, motor_power};
      2: return {7'h00, servo_ready_out};
      3: return {7'h00, uv_warning};
      4: return {7'h00, current_restrict};
      5: return {1'h0, torque_limit_pct};
      default: return {7'h00, torque_limit_pct !== 7'h64};
    endcase
  endfunction
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // the watcher settles each noted result at the falling edge
  always @(negedge core_clk) begin
    while (sel_q.size() > 0) check(obs(sel_q.pop_front()), exp_q.pop_front());
  end
  task automatic note(int s, logic [7:0] e);
    sel_q.push_back(s);
    exp_q.push_back(e);
  endtask
  task automatic step(int n);
    repeat (n) @(posedge core_clk);
  endtask
  initial begin
    int m, c, o, g;
    asps_act_t e;
    void'($urandom(44476));
    step(12);
    note(5, 8'h64);
    note(0, {6'h00, ASPS_ACT_BRAKE});
    srst <= 1'h0;
    want_on <= 1'h1;
    step(3);
    for (int i = 0; i < 36; i++) begin
      m = i % 3;
      c = (i / 3) % 3;
      o = (i / 9) % 2;
      g = i / 18;
      stop_mode_select <= 2'(m);
      ctrl_mode <= asps_ctrl_t'(2'(c));
      gr2_stop_option <= 1'(o);
      alarm_group_one <= 1'(!g);
      alarm_group_two <= 1'(g);
      step(3);
      e = (m == 2) ? ASPS_ACT_COAST : ASPS_ACT_BRAKE;
      if (g && !o && c != 2) e = ASPS_ACT_ZERO_SPEED;
      note(0, {6'h00, e});
    end
    alarm_group_one <= 1'h0;
    alarm_group_two <= 1'h0;
    $display("test 1 done");
    // below the minimum the hold time is taken as 20 ms
    power_cut_hold_time <= 10'h005;
    main_supply_ok <= 1'h0;
    step(150);
    note(1, 8'h01);
    note(2, 8'h01);
    main_supply_ok <= 1'h1;
    step(5);
    power_cut_hold_time <= 10'h014;
    main_supply_ok <= 1'h0;
    step(190);
    note(1, 8'h01);
    step(60);
    note(1, 8'h00);
    note(2, 8'h00);
    main_supply_ok <= 1'h1;
    step(3);
    note(1, 8'h01);
    note(2, 8'h01);
    $display("test 2 done");
    for (int k = 0; k < 2; k++) begin
      power_cut_hold_time <= 10'h3E8;
      main_supply_ok <= 1'h0;
      step(20);
      uv_alarm <= 1'(k);
      ctrl_supply_lost <= 1'(!k);
      step(3);
      note(1, 8'h00);
      uv_alarm <= 1'h0;
      ctrl_supply_lost <= 1'h0;
      main_supply_ok <= 1'h1;
      step(3);
      note(1, 8'h01);
    end
    want_on <= 1'h0;
    step(3);
    note(1, 8'h00);
    want_on <= 1'h1;
    step(3);
    note(1, 8'h01);
    $display("test 3 done");
    for (int u = 0; u < 3; u++) begin
      lim = 7'($urandom % 51);
      undervoltage_function_select <= 2'(u);
      sag_torque_limit <= lim;
      dc_sag <= 1'h1;
      step(4);
      note(3, {7'h00, u != 0});
      note(4, {7'h00, u != 0});
      note(5, (u == 2) ? {1'h0, lim} : 8'h64);
      dc_sag <= 1'h0;
      step(3);
      note(3, 8'h00);
      if (u == 2) note(6, 8'h01);
      step(60);
      note(5, 8'h64);
    end
    $display("test 4 done");
    step(3);
    report_and_stop();
  end
endmodule
